// *** rtl/tls_regs.svh ***
// Register offsets, field positions, reset values and fixed counts of the limit/status block
`ifndef TLS_REGS_SVH
`define TLS_REGS_SVH

// ============================================================
// Pointer addresses
`define TLS_PTR_W            8
`define TLS_PTR_LOWER_LIMIT  8'h03
`define TLS_PTR_CTRL_STATUS  8'h04
`define TLS_PTR_IDENT        8'h07

// ============================================================
// Reset values
`define TLS_LOWER_LIMIT_RST  16'h8000
`define TLS_CTRL_STATUS_RST  8'h08

// ============================================================
// Lower limit field
`define TLS_LIM_MSB          15
`define TLS_LIM_LSB          5
`define TLS_LIM_ZERO_W       5

// ============================================================
// Control/status bit positions
`define TLS_CS_TIMEOUT_OFF   7
`define TLS_CS_RES_HI        6
`define TLS_CS_RES_LO        5
`define TLS_CS_RSVD          4
`define TLS_CS_ALARM         3
`define TLS_CS_OVER          2
`define TLS_CS_UNDER         1
`define TLS_CS_DONE          0

// ============================================================
// Identification fields
`define TLS_ID_MFR_MSB       15
`define TLS_ID_MFR_LSB       8
`define TLS_ID_PROD_MSB      7
`define TLS_ID_PROD_LSB      4
`define TLS_ID_REV_MSB       3
`define TLS_ID_REV_LSB       0

`endif

// *** rtl/tls_pkg.sv ***
// Types shared by the limit/status block and its helpers
package tls_pkg;

	// Resolution codes of control/status bits 6:5
	typedef enum logic [1:0] {
		TLS_RES_11 = 2'b00,
		TLS_RES_12 = 2'b01,
		TLS_RES_13 = 2'b10,
		TLS_RES_14 = 2'b11
	} tls_res_type;

	// Control/status byte as it reads
	typedef struct packed {
		logic        bus_timeout_off;
		tls_res_type resolution_sel;
		logic        reserved_zero;
		logic        alarm_pin_level;
		logic        over_limit_flag;
		logic        under_limit_flag;
		logic        conversion_done_flag;
	} tls_csr_type;

	// Configuration bits held outside this block
	typedef struct packed {
		logic full_shutdown;
		logic alarm_enable_n;
		logic alarm_polarity;
	} tls_cfg_type;

	// Register access from the serial protocol engine
	typedef struct packed {
		logic       wr;
		logic       rd;
		logic       rd_done;
		logic [7:0] ptr;
		logic [15:0] wdata;
	} tls_acc_type;

endpackage

// *** rtl/tls_limit_cmp.sv ***
// Registered signed comparison of a measured value against a limit
`timescale 1ns/1ps
`default_nettype none

module tls_limit_cmp #(
	parameter int W = 16
) (
	// Clock and reset
	input  wire logic         clk,
	input  wire logic         rst,
	// Operands
	input  wire logic [W-1:0] a,
	input  wire logic [W-1:0] b,
	// Result
	output var  logic         a_gt_b_r
);
	generate
		if (W < 2) begin : g_bad_width
			$error("tls_limit_cmp: width too small");
		end
	endgenerate

	// Two's complement compare; limit low bits are zero so the finer
	// measured bits still count toward exceeding it
	always_ff @(posedge clk) begin
		if (rst) begin
			a_gt_b_r <= 1'b0;
		end else begin
			a_gt_b_r <= $signed(a) > $signed(b);
		end
	end
endmodule

`default_nettype wire

// *** rtl/tls_conv_seq.sv ***
// Conversion sequencer: continuous or one-shot, and the conversion-done flag
`timescale 1ns/1ps
`default_nettype none

module tls_conv_seq (
	// Clock and reset
	input  wire logic clk,
	input  wire logic rst,
	// Mode and trigger
	input  wire logic full_shutdown,
	input  wire logic one_shot,
	// Conversion engine
	input  wire logic conv_done,
	output var  logic conv_start_r,
	// Status
	output var  logic done_flag_r
);
	typedef enum logic [1:0] {
		SEQ_IDLE = 2'b00,
		SEQ_CONV = 2'b01
	} tls_seq_type;

	tls_seq_type state_r;

	// Continuous mode restarts on every completion; shutdown waits for a trigger
	always_ff @(posedge clk) begin
		if (rst) begin
			state_r      <= SEQ_IDLE;
			conv_start_r <= 1'b0;
		end else begin
			conv_start_r <= 1'b0;
			case (state_r)
				SEQ_IDLE: begin
					if (!full_shutdown || one_shot) begin
						state_r      <= SEQ_CONV;
						conv_start_r <= 1'b1;
					end
				end
				SEQ_CONV: begin
					if (conv_done) begin
						state_r <= SEQ_IDLE;
					end
				end
				default: begin
					state_r <= SEQ_IDLE;
				end
			endcase
		end
	end

	// Flag drops only for a one-shot conversion; continuous mode keeps it high
	always_ff @(posedge clk) begin
		if (rst) begin
			done_flag_r <= 1'b1;
		end else if (!full_shutdown) begin
			done_flag_r <= 1'b1;
		end else if (state_r == SEQ_IDLE && one_shot) begin
			done_flag_r <= 1'b0;
		end else if (state_r == SEQ_CONV && conv_done) begin
			done_flag_r <= 1'b1;
		end
	end
endmodule

`default_nettype wire

// *** rtl/tls_status.sv ***
// Lower limit, control/status and identification registers with alarm logic
`timescale 1ns/1ps
`default_nettype none
`include "tls_regs.svh"

module tls_status
	import tls_pkg::*;
#(
	parameter logic [7:0] MFR_ID  = 8'h5A, // Arbitrary value
	parameter logic [3:0] PROD_ID = 4'h6,  // Arbitrary value
	parameter logic [3:0] REV_ID  = 4'h3   // Arbitrary value
) (
	// Clock and reset
	input  wire logic                 clk,
	input  wire logic                 rst,
	// Register access from the serial engine
	input  wire tls_pkg::tls_acc_type acc,
	output var  logic [15:0]          rdata_r,
	// Configuration bits and strobes
	input  wire tls_pkg::tls_cfg_type cfg,
	input  wire logic                 alarm_clear,
	input  wire logic                 one_shot,
	input  wire logic                 ara_done,
	// Temperature and upper limit
	input  wire logic [15:0]          meas_temp,
	input  wire logic [15:0]          upper_limit_value,
	// Conversion engine
	input  wire logic                 conv_done,
	output var  logic                 conv_start_r,
	// Control outputs
	output var  logic                 bus_timeout_off_r,
	output var  tls_pkg::tls_res_type resolution_sel_r,
	// Alarm pin, open drain
	output var  logic                 alarm_pin_o_r,
	output var  logic                 alarm_pin_oe_r
);
	import tls_pkg::*;

	// Reset images of the writable registers, sliced per field below
	localparam logic [15:0] LOWER_RST = `TLS_LOWER_LIMIT_RST;
	localparam logic [7:0]  CSR_RST   = `TLS_CTRL_STATUS_RST;

	// ============================================================
	// Storage
	logic [`TLS_LIM_MSB:`TLS_LIM_LSB] lower_lim_r;
	logic                             alarm_active_r;
	logic                             alarm_level_r;
	logic                             over_flag_r;
	logic                             under_flag_r;
	logic                             done_flag;
	logic                             above_upper;
	logic                             below_lower;
	logic [15:0]                      lower_full;
	logic                             wr_lower;
	logic                             wr_csr;
	logic                             csr_read_done;
	tls_csr_type                      csr_view;

	assign lower_full    = {lower_lim_r, {`TLS_LIM_ZERO_W{1'b0}}};
	assign wr_lower      = acc.wr && (acc.ptr == `TLS_PTR_LOWER_LIMIT);
	assign wr_csr        = acc.wr && (acc.ptr == `TLS_PTR_CTRL_STATUS);
	assign csr_read_done = acc.rd_done && (acc.ptr == `TLS_PTR_CTRL_STATUS);

	// ============================================================
	// Comparators and conversion sequencing
	tls_limit_cmp #(.W(16)) u_cmp_upper (
		.clk      (clk),
		.rst      (rst),
		.a        (meas_temp),
		.b        (upper_limit_value),
		.a_gt_b_r (above_upper)
	);

	tls_limit_cmp #(.W(16)) u_cmp_lower (
		.clk      (clk),
		.rst      (rst),
		.a        (lower_full),
		.b        (meas_temp),
		.a_gt_b_r (below_lower)
	);

	tls_conv_seq u_seq (
		.clk           (clk),
		.rst           (rst),
		.full_shutdown (cfg.full_shutdown),
		.one_shot      (one_shot),
		.conv_done     (conv_done),
		.conv_start_r  (conv_start_r),
		.done_flag_r   (done_flag)
	);

	// ============================================================
	// Writable fields
	always_ff @(posedge clk) begin
		if (rst) begin
			lower_lim_r <= LOWER_RST[`TLS_LIM_MSB:`TLS_LIM_LSB];
		end else if (wr_lower) begin
			lower_lim_r <= acc.wdata[`TLS_LIM_MSB:`TLS_LIM_LSB];
		end
	end

	// Only bits 7:5 are stored; the rest of a written byte is status and ignored
	always_ff @(posedge clk) begin
		if (rst) begin
			bus_timeout_off_r <= CSR_RST[`TLS_CS_TIMEOUT_OFF];
			resolution_sel_r  <= tls_res_type'(CSR_RST[`TLS_CS_RES_HI:`TLS_CS_RES_LO]);
		end else if (wr_csr) begin
			bus_timeout_off_r <= acc.wdata[`TLS_CS_TIMEOUT_OFF];
			resolution_sel_r  <= tls_res_type'(acc.wdata[`TLS_CS_RES_HI:`TLS_CS_RES_LO]);
		end
	end

	// ============================================================
	// Alarm state; a new over-limit event wins over any clear in the same cycle
	always_ff @(posedge clk) begin
		if (rst) begin
			alarm_active_r <= 1'b0;
		end else if (above_upper) begin
			alarm_active_r <= 1'b1;
		end else if (below_lower || alarm_clear || ara_done) begin
			alarm_active_r <= 1'b0;
		end
	end

	// Pin level follows polarity; a disabled alarm rests at the inactive level
	always_ff @(posedge clk) begin
		if (rst) begin
			alarm_level_r  <= CSR_RST[`TLS_CS_ALARM];
			alarm_pin_oe_r <= !CSR_RST[`TLS_CS_ALARM];
			alarm_pin_o_r  <= 1'b0;
		end else begin
			alarm_level_r  <= (alarm_active_r && !cfg.alarm_enable_n) ~^ cfg.alarm_polarity;
			alarm_pin_oe_r <= !((alarm_active_r && !cfg.alarm_enable_n) ~^ cfg.alarm_polarity);
			alarm_pin_o_r  <= 1'b0;
		end
	end

	// ============================================================
	// Sticky limit flags; set wins over the read clear
	always_ff @(posedge clk) begin
		if (rst) begin
			over_flag_r <= 1'b0;
		end else if (above_upper) begin
			over_flag_r <= 1'b1;
		end else if (csr_read_done) begin
			over_flag_r <= 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			under_flag_r <= 1'b0;
		end else if (below_lower) begin
			under_flag_r <= 1'b1;
		end else if (csr_read_done) begin
			under_flag_r <= 1'b0;
		end
	end

	// ============================================================
	// Read data is captured at the read request, before any clear acts
	always_comb begin
		csr_view.bus_timeout_off      = bus_timeout_off_r;
		csr_view.resolution_sel       = resolution_sel_r;
		csr_view.reserved_zero        = 1'b0;
		csr_view.alarm_pin_level      = alarm_level_r;
		csr_view.over_limit_flag      = over_flag_r;
		csr_view.under_limit_flag     = under_flag_r;
		csr_view.conversion_done_flag = done_flag;
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			rdata_r <= 16'h0000;
		end else if (acc.rd) begin
			case (acc.ptr)
				`TLS_PTR_LOWER_LIMIT: rdata_r <= lower_full;
				`TLS_PTR_CTRL_STATUS: rdata_r <= {8'h00, csr_view};
				`TLS_PTR_IDENT:       rdata_r <= {MFR_ID, PROD_ID, REV_ID};
				default:              rdata_r <= 16'h0000;
			endcase
		end
	end
endmodule

`default_nettype wire

// *** tb/tls_status_monitor.sv ***
// Port checker of the limit/status block
`timescale 1ns/1ps
`default_nettype none
module tls_status_monitor #(
	parameter logic [7:0] MFR_ID  = 8'h5A, // Arbitrary value
	parameter logic [3:0] PROD_ID = 4'h6,  // Arbitrary value
	parameter logic [3:0] REV_ID  = 4'h3   // Arbitrary value
) (
	// Clock and reset
	input wire logic                 clk,
	input wire logic                 rst,
	// Register port
	input wire tls_pkg::tls_acc_type acc,
	input wire logic [15:0]          rdata_r,
	// Levels
	input wire tls_pkg::tls_cfg_type cfg,
	input wire logic [15:0]          meas_temp,
	input wire logic [15:0]          upper_limit_value,
	// Outputs
	input wire logic                 bus_timeout_off_r,
	input wire tls_pkg::tls_res_type resolution_sel_r,
	input wire logic                 alarm_pin_o_r,
	input wire logic                 alarm_pin_oe_r
);
	import tls_pkg::*;
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	logic over;
	logic rd4;
	logic wr4;
	assign over = $signed(meas_temp) > $signed(upper_limit_value);
	assign rd4 = acc.rd && acc.ptr == 8'h04;
	assign wr4 = acc.wr && acc.ptr == 8'h04;
	// ============================================================
	// Assertions
	property p_reset;
		$fell(rst) |-> rdata_r == 16'h0000 && !alarm_pin_oe_r && !bus_timeout_off_r && resolution_sel_r == TLS_RES_11;
	endproperty
	a_reset: assert property (p_reset) else $error("state after reset wrong");
	property p_id;
		acc.rd && acc.ptr == 8'h07 |=> rdata_r == {MFR_ID, PROD_ID, REV_ID};
	endproperty
	a_id: assert property (p_id) else $error("identification read wrong");
	property p_lim;
		acc.rd && acc.ptr == 8'h03 |=> rdata_r[4:0] == 5'h00;
	endproperty
	a_lim: assert property (p_lim) else $error("limit low bits not zero");
	property p_rsvd;
		rd4 |=> rdata_r[15:8] == 8'h00 && !rdata_r[4];
	endproperty
	a_rsvd: assert property (p_rsvd) else $error("reserved status bits set");
	property p_pin;
		rd4 |=> rdata_r[3] == !$past(alarm_pin_oe_r);
	endproperty
	a_pin: assert property (p_pin) else $error("status bit 3 differs from pin");
	property p_tmo;
		wr4 |=> bus_timeout_off_r == $past(acc.wdata[7]);
	endproperty
	a_tmo: assert property (p_tmo) else $error("time-out bit not written");
	property p_res;
		wr4 |=> resolution_sel_r == $past(acc.wdata[6:5]);
	endproperty
	a_res: assert property (p_res) else $error("resolution not written");
	property p_od;
		alarm_pin_oe_r |-> !alarm_pin_o_r;
	endproperty
	a_od: assert property (p_od) else $error("pin driven high");
	// Four cycles cover comparator, alarm register and pin register
	property p_over;
		(over && !cfg.alarm_enable_n && $stable(cfg)) [*4] |-> alarm_pin_oe_r == !cfg.alarm_polarity;
	endproperty
	a_over: assert property (p_over) else $error("alarm not active above limit");
	c_alarm: cover property (alarm_pin_oe_r ##1 !alarm_pin_oe_r);
	c_id: cover property (acc.rd && acc.ptr == 8'h07);
	c_res: cover property (resolution_sel_r == TLS_RES_14);
endmodule
bind tls_status tls_status_monitor #(.MFR_ID(MFR_ID), .PROD_ID(PROD_ID), .REV_ID(REV_ID)) i_mon (
	.clk(clk), .rst(rst), .acc(acc), .rdata_r(rdata_r), .cfg(cfg), .meas_temp(meas_temp),
	.upper_limit_value(upper_limit_value), .bus_timeout_off_r(bus_timeout_off_r),
	.resolution_sel_r(resolution_sel_r), .alarm_pin_o_r(alarm_pin_o_r), .alarm_pin_oe_r(alarm_pin_oe_r)
);
`default_nettype wire

// *** tb/tls_host_model.sv ***
// Host master model driving the register port
`timescale 1ns/1ps
`default_nettype none
module tls_host_model (
	// Clock
	input  wire logic                 clk,
	// Register port
	output var  tls_pkg::tls_acc_type acc,
	input  wire logic [15:0]          rdata_r
);
	import tls_pkg::*;
	initial acc = '0;
	// Released ptr and wdata are inverted and the strobes cleared so a stale value never looks valid
	task automatic drive(input logic w, r, d, input logic [7:0] p, input logic [15:0] x);
		@(negedge clk);
		acc = '{wr: w, rd: r, rd_done: d, ptr: p, wdata: x};
		@(negedge clk);
		acc = '{wr: 1'b0, rd: 1'b0, rd_done: 1'b0, ptr: ~p, wdata: ~x};
	endtask
	task automatic wr(input logic [7:0] p, input logic [15:0] x);
		drive(1'b1, 1'b0, 1'b0, p, x);
	endtask
	task automatic rd(input logic [7:0] p, output logic [15:0] x);
		drive(1'b0, 1'b1, 1'b0, p, 16'h0000);
		x = rdata_r;
	endtask
	task automatic fin(input logic [7:0] p);
		drive(1'b0, 1'b0, 1'b1, p, 16'h0000);
	endtask
	// Result is trusted only once the done flag reads 1
	task automatic poll(output int n);
		logic [15:0] x;
		n = 0;
		x = 16'h0000;
		while (!x[0] && n < 40) begin
			rd(8'h04, x);
			n++;
		end
	endtask
endmodule
`default_nettype wire

// *** tb/tls_status_tb.sv ***
// Self-checking bench of the limit/status block
`timescale 1ns/1ps
`default_nettype none
module tls_status_tb;
	import tls_pkg::*;
	logic clk = 1'b0;
	logic rst = 1'b1;
	tls_acc_type acc;
	tls_cfg_type cfg = '0;
	logic clr = 1'b0, osh = 1'b0, ara = 1'b0, cdone = 1'b0, cstart, tmo, pin_o, pin_oe;
	logic [15:0] meas = 16'h0000, upper = 16'h7FE0, rdata, v;
	tls_res_type res;
	int n_mismatch = 0, checks_done = 0, cyc = 0, busy = 0, starts = 0, n;
	always #12.5 clk = ~clk;
	tls_status i_dut (.clk(clk), .rst(rst), .acc(acc), .rdata_r(rdata), .cfg(cfg), .alarm_clear(clr),
		.one_shot(osh), .ara_done(ara), .meas_temp(meas), .upper_limit_value(upper), .conv_done(cdone),
		.conv_start_r(cstart), .bus_timeout_off_r(tmo), .resolution_sel_r(res), .alarm_pin_o_r(pin_o),
		.alarm_pin_oe_r(pin_oe));
	tls_host_model i_host (.clk(clk), .acc(acc), .rdata_r(rdata));
	// Conversion engine answers each start eight cycles later
	always @(negedge clk) begin
		cdone = (busy == 1);
		if (cstart) begin
			busy = 8;
			starts++;
		end else if (busy > 0)
			busy--;
	end
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			n_mismatch++;
			stop_test();
		end
	end
	task check(input logic [15:0] seen, input logic [15:0] exp);
		checks_done++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("ERROR %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task stop_test;
		if (n_mismatch == 0 && checks_done > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task lvl(input logic [15:0] m);
		@(negedge clk) meas = m;
		repeat (5) @(negedge clk);
	endtask
	task automatic pulse(ref logic s);
		@(negedge clk) s = 1'b1;
		@(negedge clk) s = 1'b0;
		repeat (3) @(negedge clk);
	endtask
	task t_regs;
		i_host.rd(8'h03, v);
		check(v, 16'h8000);
		i_host.wr(8'h07, 16'h0000);
		i_host.rd(8'h07, v);
		check(v, 16'h5A63);
		i_host.rd(8'h05, v);
		check(v, 16'h0000);
		i_host.rd(8'h04, v);
		check(v, 16'h0009);
		i_host.wr(8'h03, 16'hFFFF);
		i_host.rd(8'h03, v);
		check(v, 16'hFFE0);
		for (int i = 0; i < 4; i++) begin
			i_host.wr(8'h04, {8'h00, 1'b1, i[1:0], 5'h1F});
			i_host.rd(8'h04, v);
			check(v, {8'h00, 1'b1, i[1:0], 5'h09});
			check({13'h0000, tmo, res}, {13'h0000, 1'b1, i[1:0]});
		end
		i_host.wr(8'h04, 16'h0000);
		check(16'(tmo), 16'h0000);
		i_host.wr(8'h03, 16'h0000);
	endtask
	task t_over;
		upper = 16'h1000;
		lvl(16'h2000);
		check(16'(pin_oe), 16'h0001);
		check(16'(pin_o), 16'h0000);
		i_host.rd(8'h04, v);
		check(16'(v[3:1]), 16'h0002);
		i_host.fin(8'h04);
		i_host.rd(8'h04, v);
		check(16'(v[2]), 16'h0001);
		lvl(16'h0800);
		i_host.rd(8'h04, v);
		check(16'(v[2]), 16'h0001);
		i_host.fin(8'h04);
		i_host.rd(8'h04, v);
		check(16'(v[2]), 16'h0000);
		check(16'(pin_oe), 16'h0001);
		pulse(clr);
		check(16'(pin_oe), 16'h0000);
	endtask
	task t_under;
		lvl(16'h2000);
		lvl(16'hF000);
		check(16'(pin_oe), 16'h0000);
		i_host.rd(8'h04, v);
		check(16'(v[1]), 16'h0001);
		i_host.fin(8'h04);
		i_host.rd(8'h04, v);
		check(16'(v[1]), 16'h0001);
		lvl(16'h0800);
		i_host.fin(8'h04);
		i_host.rd(8'h04, v);
		check(16'(v[1]), 16'h0000);
		lvl(16'h2000);
		lvl(16'h0800);
		pulse(ara);
		check(16'(pin_oe), 16'h0000);
		@(negedge clk) cfg.alarm_polarity = 1'b1;
		lvl(16'h2000);
		i_host.rd(8'h04, v);
		check({15'h0000, pin_oe, v[3]}, 16'h0001);
		lvl(16'h0800);
		pulse(clr);
		i_host.rd(8'h04, v);
		check(16'(v[3]), 16'h0000);
		@(negedge clk) cfg.alarm_enable_n = 1'b1;
		lvl(16'h2000);
		i_host.rd(8'h04, v);
		check({15'h0000, pin_oe, v[3]}, 16'h0002);
		@(negedge clk) cfg.alarm_enable_n = 1'b0;
		lvl(16'h0800);
		check(16'(pin_oe), 16'h0000);
		pulse(clr);
		check(16'(pin_oe), 16'h0001);
	endtask
	task t_shot;
		@(negedge clk) cfg.full_shutdown = 1'b1;
		repeat (20) @(negedge clk);
		starts = 0;
		@(negedge clk) osh = 1'b1;
		@(negedge clk) osh = 1'b0;
		i_host.rd(8'h04, v);
		check(16'(v[0]), 16'h0000);
		i_host.poll(n);
		check(16'(n < 40), 16'h0001);
		repeat (20) @(negedge clk);
		check(starts[15:0], 16'h0001);
		@(negedge clk) cfg.full_shutdown = 1'b0;
		i_host.rd(8'h04, v);
		check(16'(v[0]), 16'h0001);
		pulse(osh);
		i_host.rd(8'h04, v);
		check(16'(v[0]), 16'h0001);
	endtask
	initial begin
		repeat (5) @(negedge clk);
		rst = 1'b0;
		repeat (20) @(negedge clk);
		t_regs();
		t_over();
		t_under();
		t_shot();
		stop_test();
	end
endmodule
`default_nettype wire
